// >>> core/pmbd_pkg.sv
// Constants shared by the command decoder: codes, slots, reset image, timing.
// Assumes a bus protocol engine that hands over decoded commands.
package pmbd_pkg;

    // Command codes.
    localparam logic [7:0] CMD_OPERATION    = 8'h01;
    localparam logic [7:0] CMD_ON_OFF       = 8'h02;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_WRITE_PROT   = 8'h10;
    localparam logic [7:0] CMD_STORE_USER   = 8'h15;
    localparam logic [7:0] CMD_RESTORE_USER = 8'h16;
    localparam logic [7:0] CMD_CAPABILITY   = 8'h19;
    localparam logic [7:0] CMD_ALERT_MASK   = 8'h1B;
    localparam logic [7:0] CMD_SETPOINT     = 8'h21;
    localparam logic [7:0] CMD_TRIM         = 8'h22;
    localparam logic [7:0] CMD_CEILING      = 8'h24;
    localparam logic [7:0] CMD_MARGIN_HIGH  = 8'h25;
    localparam logic [7:0] CMD_MARGIN_LOW   = 8'h26;
    localparam logic [7:0] CMD_SLEW_RATE    = 8'h27;
    localparam logic [7:0] CMD_LOOP_SCALE   = 8'h29;
    localparam logic [7:0] CMD_SW_FREQ      = 8'h33;
    localparam logic [7:0] CMD_VIN_ON       = 8'h35;
    localparam logic [7:0] CMD_VIN_OFF      = 8'h36;
    localparam logic [7:0] CMD_CUR_OFFSET   = 8'h39;
    localparam logic [7:0] CMD_OV_LIMIT     = 8'h40;
    localparam logic [7:0] CMD_OV_ACTION    = 8'h41;
    localparam logic [7:0] CMD_WARN_HIGH    = 8'h42;
    localparam logic [7:0] CMD_WARN_LOW     = 8'h43;

    // Storage slots of the user register image.
    localparam int NSLOT          = 19;
    localparam logic [4:0] SL_OPERATION = 5'h00;
    localparam logic [4:0] SL_ON_OFF    = 5'h01;
    localparam logic [4:0] SL_WP        = 5'h02;
    localparam logic [4:0] SL_MASK      = 5'h03;
    localparam logic [4:0] SL_SETPOINT  = 5'h04;
    localparam logic [4:0] SL_TRIM      = 5'h05;
    localparam logic [4:0] SL_CEILING   = 5'h06;
    localparam logic [4:0] SL_MHIGH     = 5'h07;
    localparam logic [4:0] SL_MLOW      = 5'h08;
    localparam logic [4:0] SL_SLEW      = 5'h09;
    localparam logic [4:0] SL_SCALE     = 5'h0A;
    localparam logic [4:0] SL_FREQ      = 5'h0B;
    localparam logic [4:0] SL_VIN_ON    = 5'h0C;
    localparam logic [4:0] SL_VIN_OFF   = 5'h0D;
    localparam logic [4:0] SL_CAL       = 5'h0E;
    localparam logic [4:0] SL_OV_LIMIT  = 5'h0F;
    localparam logic [4:0] SL_OV_ACTION = 5'h10;
    localparam logic [4:0] SL_WARN_HI   = 5'h11;
    localparam logic [4:0] SL_WARN_LO   = 5'h12;
    localparam logic [4:0] SL_NONE      = 5'h1F;

    // Reset image; output voltages in 1 mV steps, control bytes as bit fields, others linear (exp:mantissa).
    localparam logic [15:0] RESET_IMG [NSLOT] = '{
        16'h0080, 16'h0016, 16'h0000, 16'h0000, 16'h01F4, 16'h0000, 16'h1770,
        16'h0226, 16'h01C2, 16'hE801, 16'hE808, 16'h025F, 16'hF802, 16'hF801,
        16'hF800, 16'h025D, 16'h0080, 16'h0230, 16'h01B8};

    localparam logic [7:0] CAPABILITY_VALUE = 8'hB0;

    // Write protection levels.
    localparam logic [7:0] WP_ONLY_WP      = 8'h80;
    localparam logic [7:0] WP_WP_OP        = 8'h40;
    localparam logic [7:0] WP_WP_OP_CFG_VO = 8'h20;

    // Field positions.
    localparam int OP_ON          = 7;
    localparam int OP_MARGIN_LO   = 4;
    localparam logic [1:0] MARGIN_LOW  = 2'b01;
    localparam logic [1:0] MARGIN_HIGH = 2'b10;
    localparam int CFG_USE_CTRL   = 4;
    localparam int CFG_USE_CMD    = 3;
    localparam int CFG_USE_PIN    = 2;
    localparam int CFG_PIN_HIGH   = 1;
    localparam int OV_ACT_SHUT    = 7;

    // Latched status bits, also the alert mask bit positions.
    localparam int ST_OV_FAULT = 0;
    localparam int ST_OV_WARN  = 1;
    localparam int ST_UV_WARN  = 2;
    localparam int ST_CML      = 3;

    // Allowed linear exponents.
    localparam logic [4:0] EXP_ZERO  = 5'h00;
    localparam logic [4:0] EXP_ONE   = 5'h01;
    localparam logic [4:0] EXP_M1    = 5'h1F;
    localparam logic [4:0] EXP_M3    = 5'h1D;
    localparam logic [4:0] EXP_M4    = 5'h1C;

    // Timing.
    localparam int CLK_PERIOD_NS = 10;
    localparam int NS_PER_US     = 1000;
    localparam int CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;

    function automatic logic [4:0] pmbd_slot(input logic [7:0] code);
        unique case (code)
            CMD_OPERATION:   return SL_OPERATION;
            CMD_ON_OFF:      return SL_ON_OFF;
            CMD_WRITE_PROT:  return SL_WP;
            CMD_ALERT_MASK:  return SL_MASK;
            CMD_SETPOINT:    return SL_SETPOINT;
            CMD_TRIM:        return SL_TRIM;
            CMD_CEILING:     return SL_CEILING;
            CMD_MARGIN_HIGH: return SL_MHIGH;
            CMD_MARGIN_LOW:  return SL_MLOW;
            CMD_SLEW_RATE:   return SL_SLEW;
            CMD_LOOP_SCALE:  return SL_SCALE;
            CMD_SW_FREQ:     return SL_FREQ;
            CMD_VIN_ON:      return SL_VIN_ON;
            CMD_VIN_OFF:     return SL_VIN_OFF;
            CMD_CUR_OFFSET:  return SL_CAL;
            CMD_OV_LIMIT:    return SL_OV_LIMIT;
            CMD_OV_ACTION:   return SL_OV_ACTION;
            CMD_WARN_HIGH:   return SL_WARN_HI;
            CMD_WARN_LOW:    return SL_WARN_LO;
            default:         return SL_NONE;
        endcase
    endfunction : pmbd_slot

endpackage : pmbd_pkg

// >>> core/pmbd_decoder.sv
// Command decoder and register set of a buck controller.
// Assumes a same-clock bus engine that delivers decoded commands,
// and telemetry sampled on this clock.
//
// Functional notes
// - Send byte 03h clears all latched fault bits.
// - Send byte 15h stores user registers to the one-time image.
// - Send byte 16h restores user registers from that image.
// - Read of 19h gives upper nibble 1011.
// - 10h gates which writes are taken.
// - Mask 1Bh keeps chosen conditions off alert.
// - 01h sets on/off and margining.
// - 02h picks pin and command start rules.
// - Set-point 21h, default 0.5V, drives target.
// - Margin-high 25h, default 0.55V.
// - Margin-low 26h, default 0.45V.
// - Ceiling 24h, default 6V, caps target.
// - Scale 29h takes 1, 0.5, 0.25, 0.125 at exponent -3.
// - Slew 27h, default 0.125mV/us, exponent 0 to -4.
// - Frequency 33h in kHz, exponent 0 or 1, default 607kHz.
// - Input levels 35h/36h start and stop conversion.
// - Offset 39h in 0.5A steps corrects current.
// - Overvoltage limit 40h, default 0.605V, sets fault.
// - 41h picks ignore or shutdown on overvoltage.
// - High warning 42h, default 0.56V.
// - Low warning 43h, default 0.44V.
// - Trim 22h, default 0V, adds signed offset.
// - Send byte taken with or without checksum.
// - Group commands staged, applied on group strobe.
`timescale 1ns/10ps
`default_nettype none
module pmbd_decoder
    import pmbd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_code,
    input  wire logic        cmd_write,
    input  wire logic [15:0] cmd_data,
    input  wire logic        cmd_pec,
    input  wire logic        cmd_pec_ok,
    input  wire logic        cmd_group,
    input  wire logic        group_exec,
    input  wire logic        rd_req,
    input  wire logic [7:0]  rd_code,
    input  wire logic        enable_pin,
    input  wire logic [15:0] vout_sense,
    input  wire logic [10:0] vin_sense,
    input  wire logic [11:0] iout_raw,
    output logic      [15:0] rd_data,
    output logic             rd_ack,
    output logic             conv_enable,
    output logic      [15:0] vout_target,
    output logic      [15:0] fb_ref,
    output logic      [11:0] sw_freq_khz,
    output logic      [11:0] iout_corr,
    output logic      [3:0]  status,
    output logic             alert_n
);

    logic [15:0] user_reg [NSLOT];
    logic [15:0] otp_img  [NSLOT];

    logic        en_meta;
    logic        en_sync;

    logic        stg_valid;
    logic [7:0]  stg_code;
    logic        stg_write;
    logic [15:0] stg_data;

    logic        x_valid;
    logic [7:0]  x_code;
    logic        x_write;
    logic [15:0] x_data;
    logic [4:0]  x_slot;

    logic        wp_ok;
    logic        fmt_ok;

    logic        wr_ok;
    logic        do_clear;
    logic        do_store;
    logic        do_restore;
    logic        reject;

    logic        vin_ok;
    logic        run_req;

    logic [15:0] sel_point;
    logic [15:0] next_target;

    logic [15:0] slew_acc;
    logic [15:0] slew_thresh;
    logic [16:0] slew_sum;

    logic [3:0]  set_vec;

    // Enable pin comes from outside the clock domain.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            en_meta <= 1'b0;
            en_sync <= 1'b0;
        end
        else
        begin
            en_meta <= enable_pin;
            en_sync <= en_meta;
        end
    end

    // A bad checksum drops the group entry so nothing half-checked is applied.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            stg_valid <= 1'b0;
            stg_code  <= 8'h00;
            stg_write <= 1'b0;
            stg_data  <= 16'h0000;
        end
        else if (cmd_valid && cmd_group && !(cmd_pec && !cmd_pec_ok))
        begin
            stg_valid <= 1'b1;
            stg_code  <= cmd_code;
            stg_write <= cmd_write;
            stg_data  <= cmd_data;
        end
        else if (group_exec)
        begin
            stg_valid <= 1'b0;
        end
    end

    always_comb
    begin
        x_valid = (cmd_valid && !cmd_group && !(cmd_pec && !cmd_pec_ok))
                  || (group_exec && stg_valid);
        x_code  = (group_exec && stg_valid) ? stg_code : cmd_code;
        x_write = (group_exec && stg_valid) ? stg_write : cmd_write;
        x_data  = (group_exec && stg_valid) ? stg_data : cmd_data;
        x_slot  = pmbd_slot(x_code);
    end

    always_comb
    begin
        unique case (user_reg[SL_WP][7:0])
            WP_ONLY_WP:      wp_ok = (x_code == CMD_WRITE_PROT);
            WP_WP_OP:        wp_ok = (x_code == CMD_WRITE_PROT) || (x_code == CMD_OPERATION);
            WP_WP_OP_CFG_VO: wp_ok = (x_code == CMD_WRITE_PROT) || (x_code == CMD_OPERATION)
                                     || (x_code == CMD_ON_OFF) || (x_code == CMD_SETPOINT);
            default:         wp_ok = 1'b1;
        endcase
    end

    always_comb
    begin
        unique case (x_code)
            CMD_SLEW_RATE:  fmt_ok = (x_data[15:11] == EXP_ZERO)
                                     || (x_data[15:11] >= EXP_M4);
            CMD_LOOP_SCALE: fmt_ok = (x_data[15:11] == EXP_M3)
                                     && (x_data[10:0] inside {11'h001, 11'h002,
                                                              11'h004, 11'h008});
            CMD_SW_FREQ:    fmt_ok = (x_data[15:11] == EXP_ZERO)
                                     || (x_data[15:11] == EXP_ONE);
            CMD_VIN_ON, CMD_VIN_OFF,
            CMD_CUR_OFFSET: fmt_ok = (x_data[15:11] == EXP_M1);
            default:        fmt_ok = 1'b1;
        endcase
    end

    always_comb
    begin
        wr_ok      = x_valid && x_write && (x_slot != SL_NONE) && wp_ok && fmt_ok;
        do_clear   = x_valid && !x_write && wp_ok && (x_code == CMD_CLEAR_FAULTS);
        do_store   = x_valid && !x_write && wp_ok && (x_code == CMD_STORE_USER);
        do_restore = x_valid && !x_write && wp_ok && (x_code == CMD_RESTORE_USER);
        reject     = (x_valid && !wr_ok && !do_clear && !do_store && !do_restore)
                     || (cmd_valid && cmd_pec && !cmd_pec_ok);
    end

    // Byte-wide registers keep the upper byte at zero.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            user_reg <= RESET_IMG;
        end
        else if (do_restore)
        begin
            user_reg <= otp_img;
        end
        else if (wr_ok)
        begin
            if (x_code inside {CMD_OPERATION, CMD_ON_OFF, CMD_WRITE_PROT, CMD_OV_ACTION})
                user_reg[x_slot] <= {8'h00, x_data[7:0]};
            else
                user_reg[x_slot] <= x_data;
        end
    end

    // The one-time image starts from the reset image; a store overwrites it.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            otp_img <= RESET_IMG;
        else if (do_store)
            otp_img <= user_reg;
    end

    // Conditions set their bit every cycle they hold; a set beats a clear.
    always_comb
    begin
        set_vec              = 4'h0;
        set_vec[ST_OV_FAULT] = vout_sense > user_reg[SL_OV_LIMIT];
        set_vec[ST_OV_WARN]  = vout_sense > user_reg[SL_WARN_HI];
        set_vec[ST_UV_WARN]  = vout_sense < user_reg[SL_WARN_LO];
        set_vec[ST_CML]      = reject;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            status <= 4'h0;
        else
            status <= (do_clear ? 4'h0 : status) | set_vec;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            alert_n <= 1'b1;
        else
            alert_n <= ~|(status & ~user_reg[SL_MASK][3:0]);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            vin_ok <= 1'b0;
        else if (vin_sense > user_reg[SL_VIN_ON][10:0])
            vin_ok <= 1'b1;
        else if (vin_sense < user_reg[SL_VIN_OFF][10:0])
            vin_ok <= 1'b0;
    end

    always_comb
    begin
        if (!user_reg[SL_ON_OFF][CFG_USE_CTRL])
            run_req = 1'b1;
        else
            run_req = (!user_reg[SL_ON_OFF][CFG_USE_CMD] || user_reg[SL_OPERATION][OP_ON])
                      && (!user_reg[SL_ON_OFF][CFG_USE_PIN]
                          || (en_sync == user_reg[SL_ON_OFF][CFG_PIN_HIGH]));
    end

    // Overvoltage shutdown stays until the fault is cleared.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            conv_enable <= 1'b0;
        else
            conv_enable <= run_req && vin_ok
                           && !(status[ST_OV_FAULT]
                                && user_reg[SL_OV_ACTION][OV_ACT_SHUT]);
    end

    always_comb
    begin
        logic signed [17:0] sum;
        sum = 18'sh00000;
        unique case (user_reg[SL_OPERATION][OP_MARGIN_LO+1:OP_MARGIN_LO])
            MARGIN_HIGH: sel_point = user_reg[SL_MHIGH];
            MARGIN_LOW:  sel_point = user_reg[SL_MLOW];
            default:     sel_point = user_reg[SL_SETPOINT];
        endcase
        sum = $signed({2'b00, sel_point})
              + $signed({{2{user_reg[SL_TRIM][15]}}, user_reg[SL_TRIM]});
        if (sum[17])
            next_target = 16'h0000;
        else if (sum > $signed({2'b00, user_reg[SL_CEILING]}))
            next_target = user_reg[SL_CEILING];
        else
            next_target = sum[15:0];
    end

    // One millivolt step each time the rate accumulator passes a microsecond
    // worth of cycles scaled by the exponent; a zero rate jumps at once.
    always_comb
    begin
        slew_thresh = 16'(CYC_PER_US) << (user_reg[SL_SLEW][15] ?
                                          3'(~user_reg[SL_SLEW][13:11] + 3'h1) : 3'h0);
        slew_sum    = {1'b0, slew_acc} + {6'h00, user_reg[SL_SLEW][10:0]};
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            vout_target <= RESET_IMG[SL_SETPOINT];
            slew_acc    <= 16'h0000;
        end
        else if (vout_target == next_target)
        begin
            slew_acc <= 16'h0000;
        end
        else if (user_reg[SL_SLEW][10:0] == 11'h000)
        begin
            vout_target <= next_target;
        end
        else if (slew_sum >= {1'b0, slew_thresh})
        begin
            slew_acc    <= 16'(slew_sum - {1'b0, slew_thresh});
            vout_target <= (vout_target < next_target) ? vout_target + 16'h0001
                                                       : vout_target - 16'h0001;
        end
        else
        begin
            slew_acc <= slew_sum[15:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            fb_ref <= 16'h0000;
        else
            fb_ref <= 16'(({3'b000, vout_target} * {15'h0000, user_reg[SL_SCALE][3:0]})
                          >> 3);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            sw_freq_khz <= 12'h000;
        else
            sw_freq_khz <= {1'b0, user_reg[SL_FREQ][10:0]} << user_reg[SL_FREQ][11];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            iout_corr <= 12'h000;
        else
            iout_corr <= iout_raw + {user_reg[SL_CAL][10], user_reg[SL_CAL][10:0]};
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rd_data <= 16'h0000;
            rd_ack  <= 1'b0;
        end
        else
        begin
            rd_ack <= rd_req;
            if (rd_code == CMD_CAPABILITY)
                rd_data <= {8'h00, CAPABILITY_VALUE};
            else if (pmbd_slot(rd_code) != SL_NONE)
                rd_data <= user_reg[pmbd_slot(rd_code)];
            else
                rd_data <= 16'h0000;
        end
    end

endmodule : pmbd_decoder
`default_nettype wire

// >>> tb/pmbd_props.sv
// Port checker for the command decoder.
// Assumes a bind onto the decoder's ports.
`timescale 1ns/10ps
`default_nettype none
module pmbd_props
    import pmbd_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_code,
    input wire logic        cmd_write,
    input wire logic [15:0] cmd_data,
    input wire logic        cmd_group,
    input wire logic        group_exec,
    input wire logic        rd_req,
    input wire logic [7:0]  rd_code,
    input wire logic [11:0] iout_raw,
    input wire logic [15:0] rd_data,
    input wire logic        rd_ack,
    input wire logic [11:0] sw_freq_khz,
    input wire logic [11:0] iout_corr,
    input wire logic [3:0]  status,
    input wire logic        alert_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // History checks wait for quiet cycles after reset or a command.
    logic [1:0] live_q;
    logic       direct;
    assign direct = cmd_valid && !cmd_group && !group_exec;
    always_ff @(posedge clk)
    begin
        if (!rst_n || cmd_valid || group_exec)
            live_q <= 2'h0;
        else if (live_q != 2'h3)
            live_q <= live_q + 2'h1;
    end

    property p_rd_ack; rd_req |=> rd_ack; endproperty
    a_rd_ack: assert property (p_rd_ack) else $error("read not answered");
    property p_no_ack; !rd_req |=> !rd_ack; endproperty
    a_no_ack: assert property (p_no_ack) else $error("answer without read");
    property p_cap;
        rd_req && rd_code == CMD_CAPABILITY |=> rd_data[7:4] == 4'hB && rd_data[15:8] == 8'h00;
    endproperty
    a_cap: assert property (p_cap) else $error("capability byte wrong");
    property p_ro; direct && cmd_write && cmd_code == CMD_CAPABILITY |-> ##[1:2] status[ST_CML];
    endproperty
    a_ro: assert property (p_ro) else $error("read-only write not flagged");
    property p_scale;
        direct && cmd_write && cmd_code == CMD_LOOP_SCALE
            && !(cmd_data inside {16'hE801, 16'hE802, 16'hE804, 16'hE808})
            |-> ##[1:2] status[ST_CML];
    endproperty
    a_scale: assert property (p_scale) else $error("bad scale exponent taken");
    property p_sticky;
        (|($past(status) & ~status)) |-> $past(cmd_valid && cmd_code == CMD_CLEAR_FAULTS)
            || $past(group_exec);
    endproperty
    a_sticky: assert property (p_sticky) else $error("status dropped without clear");
    property p_alert; status == 4'h0 |=> alert_n; endproperty
    a_alert: assert property (p_alert) else $error("alert with no status");
    property p_freq;
        live_q == 2'h3 |-> $stable(sw_freq_khz);
    endproperty
    a_freq: assert property (p_freq) else $error("frequency moved unasked");
    property p_iout;
        live_q == 2'h3
            |-> (iout_corr - $past(iout_raw)) == ($past(iout_corr) - $past(iout_raw, 2));
    endproperty
    a_iout: assert property (p_iout) else $error("current offset not constant");

    c_cap: cover property (rd_req && rd_code == CMD_CAPABILITY);
    c_ov: cover property ($rose(status[ST_OV_FAULT]));
    c_alert: cover property ($fell(alert_n));
endmodule : pmbd_props
`default_nettype wire

// >>> tb/pmbd_host.sv
// Host model: issues commands, group strobes and reads.
// Assumes the bench calls its tasks on the decoder clock.
`timescale 1ns/10ps
`default_nettype none
module pmbd_host (
    input  wire logic        clk,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_ack,
    output logic             cmd_valid,
    output logic      [7:0]  cmd_code,
    output logic             cmd_write,
    output logic      [15:0] cmd_data,
    output logic             cmd_pec,
    output logic             cmd_pec_ok,
    output logic             cmd_group,
    output logic             group_exec,
    output logic             rd_req,
    output logic      [7:0]  rd_code
);
    initial
    begin
        {cmd_valid, cmd_write, cmd_pec, cmd_pec_ok, cmd_group, group_exec, rd_req} = 7'h00;
        {cmd_code, cmd_data, rd_code} = 32'h00000000;
    end

    task automatic send(input logic [7:0] c, input logic w, input logic [15:0] d,
                        input logic p, input logic pok, input logic g);
        @(posedge clk);
        cmd_valid  <= 1'b1;
        cmd_code   <= c;
        cmd_write  <= w;
        cmd_data   <= d;
        cmd_pec    <= p;
        cmd_pec_ok <= pok;
        cmd_group  <= g;
        @(posedge clk);
        cmd_valid  <= 1'b0;
        cmd_group  <= 1'b0;
        // Flip released lines so stale data cannot pass.
        cmd_code   <= ~c;
        cmd_data   <= ~d;
    endtask : send

    task automatic grp;
        @(posedge clk);
        group_exec <= 1'b1;
        @(posedge clk);
        group_exec <= 1'b0;
    endtask : grp

    task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic a);
        @(posedge clk);
        rd_req  <= 1'b1;
        rd_code <= c;
        @(posedge clk);
        rd_req  <= 1'b0;
        #1;
        d = rd_data;
        a = rd_ack;
        @(posedge clk);
        rd_code <= ~c;
    endtask : rd
endmodule : pmbd_host
`default_nettype wire

// >>> tb/pmbus_command_set_decoder_tb_top.sv
// Self-checking bench for the command decoder.
// Assumes pmbd_host as the far side and the checker bound below.
`timescale 1ns/10ps
`default_nettype none
module pmbus_command_set_decoder_tb_top;
    import pmbd_pkg::*;
    logic        clk, rst_n, enable_pin, rd_ack, conv_enable, alert_n, ra;
    logic        cmd_valid, cmd_write, cmd_pec, cmd_pec_ok, cmd_group, group_exec, rd_req;
    logic [7:0]  cmd_code, rd_code;
    logic [15:0] cmd_data, rd_data, vout_sense, vout_target, fb_ref, rv;
    logic [10:0] vin_sense;
    logic [11:0] iout_raw, sw_freq_khz, iout_corr;
    logic [3:0]  status;
    int          errors = 0;
    int          total_checks = 0;
    logic [7:0]  codes [19] = '{8'h01, 8'h02, 8'h10, 8'h1B, 8'h21, 8'h22, 8'h24, 8'h25, 8'h26,
        8'h27, 8'h29, 8'h33, 8'h35, 8'h36, 8'h39, 8'h40, 8'h41, 8'h42, 8'h43};
    logic [7:0]  bad_c [5] = '{8'h29, 8'h27, 8'h33, 8'h35, 8'h19};
    logic [15:0] bad_d [5] = '{16'hE803, 16'h0801, 16'h125F, 16'h0002, 16'h0000};

    pmbd_decoder i_dut (.*);
    pmbd_host i_host (.*);

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        i_host.send(c, 1'b1, d, 1'b0, 1'b0, 1'b0);
    endtask : wr
    task automatic sb(input logic [7:0] c);
        i_host.send(c, 1'b0, 16'h0000, 1'b0, 1'b0, 1'b0);
    endtask : sb
    task automatic rchk(input logic [7:0] c, input logic [15:0] exp);
        i_host.rd(c, rv, ra);
        chk({15'h0, ra}, 16'h0001);
        chk(rv, exp);
    endtask : rchk
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        test_done();
    end
    initial
    begin
        rst_n      = 1'b0;
        enable_pin = 1'b1;
        vout_sense = 16'h01F4;
        vin_sense  = 11'h018;
        iout_raw   = 12'h010;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        settle(40);
        for (int i = 0; i < 19; i++)
            rchk(codes[i], RESET_IMG[i]);
        rchk(CMD_CAPABILITY, 16'h00B0);
        chk({4'h0, sw_freq_khz}, 16'h025F);
        chk({15'h0, conv_enable}, 16'h0001);
        $display("test reset done");
        wr(CMD_SETPOINT, 16'h01F6);
        settle(20);
        chk({15'h0, vout_target == 16'h01F6}, 16'h0000);
        settle(1800);
        chk(vout_target, 16'h01F6);
        $display("test slew done");
        for (int i = 0; i < 5; i++)
            wr(bad_c[i], bad_d[i]);
        rchk(CMD_LOOP_SCALE, 16'hE808);
        rchk(CMD_SLEW_RATE, 16'hE801);
        rchk(CMD_SW_FREQ, 16'h025F);
        rchk(CMD_VIN_ON, 16'hF802);
        chk({12'h0, status}, 16'h0008);
        i_host.send(CMD_CLEAR_FAULTS, 1'b0, 16'h0000, 1'b1, 1'b0, 1'b0);
        settle(4);
        chk({12'h0, status}, 16'h0008);
        i_host.send(CMD_CLEAR_FAULTS, 1'b0, 16'h0000, 1'b1, 1'b1, 1'b0);
        settle(4);
        chk({12'h0, status}, 16'h0000);
        wr(CMD_SW_FREQ, 16'h092C);
        settle(4);
        chk({4'h0, sw_freq_khz}, 16'h0258);
        $display("test refusals done");
        wr(CMD_WRITE_PROT, 16'h0080);
        wr(CMD_SETPOINT, 16'h0300);
        rchk(CMD_SETPOINT, 16'h01F6);
        wr(CMD_WRITE_PROT, 16'h0000);
        sb(CMD_CLEAR_FAULTS);
        $display("test protect done");
        wr(CMD_SLEW_RATE, 16'hE800);
        wr(CMD_SETPOINT, 16'h01F4);
        wr(CMD_OPERATION, 16'h00A0);
        settle(6);
        chk(vout_target, 16'h0226);
        wr(CMD_OPERATION, 16'h0090);
        settle(6);
        chk(vout_target, 16'h01C2);
        wr(CMD_OPERATION, 16'h0080);
        wr(CMD_TRIM, 16'h000A);
        settle(6);
        chk(vout_target, 16'h01FE);
        wr(CMD_CEILING, 16'h01F8);
        settle(6);
        chk(vout_target, 16'h01F8);
        wr(CMD_CEILING, 16'h1770);
        wr(CMD_TRIM, 16'h0000);
        wr(CMD_LOOP_SCALE, 16'hE804);
        settle(6);
        chk(fb_ref, 16'h00FA);
        wr(CMD_LOOP_SCALE, 16'hE808);
        $display("test target done");
        wr(CMD_ON_OFF, 16'h001E);
        wr(CMD_OPERATION, 16'h0000);
        settle(6);
        chk({15'h0, conv_enable}, 16'h0000);
        wr(CMD_OPERATION, 16'h0080);
        enable_pin <= 1'b0;
        settle(6);
        chk({15'h0, conv_enable}, 16'h0000);
        enable_pin <= 1'b1;
        vin_sense  <= 11'h000;
        settle(6);
        chk({15'h0, conv_enable}, 16'h0000);
        vin_sense <= 11'h002;
        settle(6);
        chk({15'h0, conv_enable}, 16'h0000);
        vin_sense <= 11'h003;
        settle(6);
        chk({15'h0, conv_enable}, 16'h0001);
        $display("test on_off done");
        vout_sense <= 16'h025E;
        settle(4);
        chk({12'h0, status}, 16'h0003);
        chk({14'h0, conv_enable, alert_n}, 16'h0000);
        vout_sense <= 16'h01F4;
        wr(CMD_ALERT_MASK, 16'h0003);
        settle(4);
        chk({15'h0, alert_n}, 16'h0001);
        sb(CMD_CLEAR_FAULTS);
        settle(6);
        chk({11'h0, conv_enable, status}, 16'h0010);
        vout_sense <= 16'h0100;
        settle(4);
        chk({11'h0, alert_n, status}, 16'h0004);
        vout_sense <= 16'h01F4;
        wr(CMD_OV_ACTION, 16'h0000);
        sb(CMD_CLEAR_FAULTS);
        vout_sense <= 16'h025E;
        settle(6);
        chk({15'h0, conv_enable}, 16'h0001);
        vout_sense <= 16'h01F4;
        sb(CMD_CLEAR_FAULTS);
        $display("test faults done");
        wr(CMD_SETPOINT, 16'h0300);
        sb(CMD_STORE_USER);
        wr(CMD_SETPOINT, 16'h0100);
        sb(CMD_RESTORE_USER);
        rchk(CMD_SETPOINT, 16'h0300);
        i_host.send(CMD_SETPOINT, 1'b1, 16'h0280, 1'b0, 1'b0, 1'b1);
        rchk(CMD_SETPOINT, 16'h0300);
        i_host.grp();
        rchk(CMD_SETPOINT, 16'h0280);
        wr(CMD_CUR_OFFSET, 16'hF802);
        settle(4);
        chk({4'h0, iout_corr}, 16'h0012);
        $display("test image done");
        test_done();
    end
endmodule : pmbus_command_set_decoder_tb_top

bind pmbd_decoder pmbd_props i_props (.*);
`default_nettype wire
